// [core/iwt_core.sv]
// Word-level master receive and slave handling of the serial bus interface.
`timescale 1ns/100ps
`include "iwt_defs.svh"
module iwt_core (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic clock_pin_i,
    output logic clock_pin_o,
    output logic clock_pin_oe,
    input wire logic data_pin_i,
    output logic data_pin_o,
    output logic data_pin_oe,
    output logic serial_interrupt
);
    import iwt_pkg::*;

    logic scl_s, sda_s, scl_d1_q, sda_d1_q;
    logic [7:0] ctrl_one_q, own_addr_q, shift_q, data_buf_q, cnt_q;
    logic pin_q, mst_q, trx_q, bb_q, al_q, aas_q, ad0_q, lrb_q;
    logic [3:0] bit_q, bits_tot;
    logic ack_phase_q, addr_phase_q, addressed_q, drive_low_q, hold_q, rd_ack_q;
    iwt_state_t state_q;
    logic wr_hit, rd_hit, wr_data, rd_data, wr_ctrl_two, resume;
    logic scl_rise, scl_fall, start_det, stop_det, word_done, end_of_unit;

    iwt_sync u_scl_sync (.clk(clk), .nrst(nrst), .din(clock_pin_i), .dout(scl_s));
    iwt_sync u_sda_sync (.clk(clk), .nrst(nrst), .din(data_pin_i), .dout(sda_s));

    function automatic logic [3:0] word_len(input logic [2:0] bc);
        word_len = (bc == 3'b000) ? `IWT_BC_EIGHT : {1'b0, bc};
    endfunction : word_len

    // Slave read answers in one wait cycle so read data always comes from a register.
    assign wr_hit = avs_write && !avs_waitrequest;
    assign rd_hit = avs_read && !avs_waitrequest;
    assign avs_waitrequest = avs_read && !rd_ack_q;
    assign wr_data = wr_hit && (avs_address == `IWT_OFS_DATA_BUF);
    assign rd_data = rd_hit && (avs_address == `IWT_OFS_DATA_BUF);
    assign wr_ctrl_two = wr_hit && (avs_address == `IWT_OFS_CTRL_TWO);
    assign resume = wr_data || (wr_ctrl_two && avs_writedata[`IWT_PIN_BIT]);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_ack_q <= 1'b0;
        end else begin
            rd_ack_q <= avs_read && !rd_ack_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !rd_ack_q) begin
            if (avs_address == `IWT_OFS_CTRL_ONE) begin
                avs_readdata <= {24'h00_0000, ctrl_one_q};
            end else if (avs_address == `IWT_OFS_STATUS_TWO) begin
                avs_readdata <= {24'h00_0000, mst_q, trx_q, bb_q, pin_q, al_q, aas_q, ad0_q, lrb_q};
            end else if (avs_address == `IWT_OFS_DATA_BUF) begin
                avs_readdata <= {24'h00_0000, data_buf_q};
            end else if (avs_address == `IWT_OFS_OWN_ADDR) begin
                avs_readdata <= {24'h00_0000, own_addr_q};
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_one_q <= `IWT_CTRL_ONE_RST;
            own_addr_q <= `IWT_OWN_ADDR_RST;
        end else if (wr_hit && avs_address == `IWT_OFS_CTRL_ONE) begin
            ctrl_one_q <= avs_writedata[7:0];
        end else if (wr_hit && avs_address == `IWT_OFS_OWN_ADDR) begin
            own_addr_q <= avs_writedata[7:0];
        end
    end

    assign bits_tot = word_len(ctrl_one_q[`IWT_BC_MSB:`IWT_BC_LSB]);
    assign scl_rise = scl_s && !scl_d1_q;
    assign scl_fall = !scl_s && scl_d1_q;
    assign start_det = scl_s && scl_d1_q && sda_d1_q && !sda_s;
    assign stop_det = scl_s && scl_d1_q && !sda_d1_q && sda_s;
    // A unit ends on the falling edge after the ack bit, or after the last data bit when no ack clock.
    assign word_done = scl_fall && (ack_phase_q || (bit_q == bits_tot && !ctrl_one_q[`IWT_ACK_BIT]));
    assign end_of_unit = word_done && (mst_q || addressed_q || al_q);

    // Address recognition is combinational so that the ack can be driven on the very falling edge
    // that ends the eighth bit; registered flags would only be seen one bit time too late.
    logic addr_hit;
    assign addr_hit = addr_phase_q && !mst_q && !ctrl_one_q[`IWT_ADDRESS_DETECT_DISABLE_BIT] && !own_addr_q[`IWT_ALS_BIT] &&
        (shift_q == `IWT_GCALL || shift_q[7:1] == own_addr_q[7:1]);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end else begin
            scl_d1_q <= scl_s;
            sda_d1_q <= sda_s;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lrb_q <= 1'b0;
        end else if (scl_rise) begin
            lrb_q <= sda_s;
        end
    end

    // Bit counting, shifting and slave address recognition.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_q <= 4'h0;
            shift_q <= `IWT_ZERO8;
            ack_phase_q <= 1'b0;
            addr_phase_q <= 1'b0;
            addressed_q <= 1'b0;
            aas_q <= 1'b0;
            ad0_q <= 1'b0;
        end else begin
            if (start_det || stop_det) begin
                bit_q <= 4'h0;
                ack_phase_q <= 1'b0;
                addr_phase_q <= start_det;
                addressed_q <= 1'b0;
                ad0_q <= 1'b0;
            end else if (scl_rise && !ack_phase_q) begin
                shift_q <= {shift_q[6:0], sda_s};
                bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == bits_tot && !ack_phase_q && ctrl_one_q[`IWT_ACK_BIT]) begin
                ack_phase_q <= 1'b1;
                if (addr_hit) begin
                    if (shift_q == `IWT_GCALL) begin
                        aas_q <= 1'b1;
                        ad0_q <= 1'b1;
                        addressed_q <= 1'b1;
                    end else if (shift_q[7:1] == own_addr_q[7:1]) begin
                        aas_q <= 1'b1;
                        addressed_q <= 1'b1;
                    end
                end
            end else if (word_done) begin
                bit_q <= 4'h0;
                ack_phase_q <= 1'b0;
                addr_phase_q <= 1'b0;
            end
            if (wr_data || rd_data) begin
                aas_q <= 1'b0;
            end
        end
    end

    // Direction, mode and arbitration flags.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mst_q <= 1'b0;
            trx_q <= 1'b0;
            bb_q <= 1'b0;
            al_q <= 1'b0;
        end else begin
            if (start_det) begin
                bb_q <= 1'b1;
            end else if (stop_det) begin
                bb_q <= 1'b0;
            end
            if (mst_q && trx_q && scl_rise && !drive_low_q && !sda_s && !ack_phase_q) begin
                al_q <= 1'b1;
                mst_q <= 1'b0;
            end else if (wr_data || rd_data || wr_ctrl_two) begin
                al_q <= 1'b0;
            end
            if (wr_ctrl_two) begin
                mst_q <= avs_writedata[`IWT_MST_BIT];
                trx_q <= avs_writedata[`IWT_TRX_BIT];
            end else if (scl_fall && bit_q == bits_tot && !ack_phase_q && addr_phase_q && !mst_q) begin
                trx_q <= shift_q[0];
            end
        end
    end

    // Received data hold; after an address with R/W low it holds that address byte, after a read address its old value.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_buf_q <= `IWT_ZERO8;
        end else if (wr_data) begin
            data_buf_q <= avs_writedata[7:0];
        end else if (word_done && !trx_q) begin
            data_buf_q <= shift_q;
        end
    end

    // Pending flag: the end-of-unit event wins over a software set in the same cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_q <= 1'b1;
        end else if (end_of_unit) begin
            pin_q <= 1'b0;
        end else if (resume) begin
            pin_q <= 1'b1;
        end
    end

    assign serial_interrupt = !pin_q;

    // Clock generation for the master and clock stretching for every mode.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= IWT_IDLE;
            cnt_q <= `IWT_ZERO8;
            hold_q <= 1'b0;
        end else begin
            case (state_q)
                IWT_IDLE: begin
                    hold_q <= 1'b0;
                    cnt_q <= `IWT_ZERO8;
                    if (end_of_unit) begin
                        state_q <= IWT_HOLD;
                        hold_q <= 1'b1;
                    end else if (mst_q && bb_q && pin_q) begin
                        state_q <= IWT_LOW;
                    end
                end
                IWT_HOLD: begin
                    // The low-period count starts only once software resumes.
                    cnt_q <= `IWT_ZERO8;
                    if (pin_q) begin
                        state_q <= IWT_LOW;
                    end
                end
                IWT_LOW: begin
                    hold_q <= 1'b1;
                    if (!pin_q) begin
                        // A unit ends on our own falling edge, so it is seen here while we drive low.
                        // Stay low and wait for software instead of running on into the next word.
                        cnt_q <= `IWT_ZERO8;
                        state_q <= IWT_HOLD;
                    end else if (cnt_q == `IWT_TLOW_CYCLES) begin
                        cnt_q <= `IWT_ZERO8;
                        hold_q <= 1'b0;
                        state_q <= mst_q ? IWT_HIGH : IWT_SLAVE;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                IWT_HIGH: begin
                    hold_q <= 1'b0;
                    if (end_of_unit) begin
                        state_q <= IWT_HOLD;
                        hold_q <= 1'b1;
                    end else if (!mst_q) begin
                        state_q <= IWT_SLAVE;
                    end else if (!scl_s) begin
                        cnt_q <= `IWT_ZERO8;
                    end else if (cnt_q == `IWT_THIGH_CYCLES) begin
                        cnt_q <= `IWT_ZERO8;
                        state_q <= IWT_LOW;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                IWT_SLAVE: begin
                    hold_q <= 1'b0;
                    if (end_of_unit) begin
                        state_q <= IWT_HOLD;
                        hold_q <= 1'b1;
                    end else if (!bb_q) begin
                        state_q <= IWT_IDLE;
                    end
                end
                default: begin
                    state_q <= IWT_IDLE;
                end
            endcase
        end
    end

    // Data drive: ack low as receiver, released on the no-ack bit, shift out as transmitter.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            drive_low_q <= 1'b0;
        end else if (scl_fall) begin
            if (bit_q == bits_tot && !ack_phase_q && ctrl_one_q[`IWT_ACK_BIT]) begin
                if (addr_phase_q && !mst_q) begin
                    drive_low_q <= addr_hit;
                end else begin
                    drive_low_q <= !trx_q && (mst_q || addressed_q);
                end
            end else if (trx_q && !ack_phase_q && bit_q < bits_tot) begin
                drive_low_q <= !data_buf_q[3'(bits_tot - bit_q - 4'h1)];
            end else begin
                drive_low_q <= 1'b0;
            end
        end else if (wr_data && trx_q && !mst_q) begin
            // The first bit of a slave-sent word must stand before the held clock is released.
            drive_low_q <= !avs_writedata[3'(bits_tot - 4'h1)];
        end else if (start_det || stop_det) begin
            drive_low_q <= 1'b0;
        end
    end

    assign clock_pin_o = 1'b0;
    assign clock_pin_oe = hold_q || (state_q == IWT_LOW);
    assign data_pin_o = 1'b0;
    assign data_pin_oe = drive_low_q;
endmodule : iwt_core

// [core/iwt_defs.svh]
// Register offsets, field positions, reset values and timing counts of the word transfer block.
`ifndef IWT_DEFS_SVH
`define IWT_DEFS_SVH
`define IWT_OFS_CTRL_ONE 4'h0
`define IWT_OFS_CTRL_TWO 4'h1
`define IWT_OFS_STATUS_TWO 4'h2
`define IWT_OFS_DATA_BUF 4'h3
`define IWT_OFS_OWN_ADDR 4'h4
`define IWT_ADDR_W 4
`define IWT_BC_LSB 0
`define IWT_BC_MSB 2
`define IWT_ACK_BIT 4
`define IWT_ADDRESS_DETECT_DISABLE_BIT 3
`define IWT_PIN_BIT 4
`define IWT_TRX_BIT 6
`define IWT_MST_BIT 7
`define IWT_ST_LRB 0
`define IWT_ST_AD0 1
`define IWT_ST_AAS 2
`define IWT_ST_AL 3
`define IWT_ST_PIN 4
`define IWT_ST_BB 5
`define IWT_ST_TRX 6
`define IWT_ST_MST 7
`define IWT_ALS_BIT 0
`define IWT_CTRL_ONE_RST 8'h10
`define IWT_CTRL_TWO_RST 8'h10
`define IWT_OWN_ADDR_RST 8'h00
`define IWT_BC_EIGHT 4'h8
`define IWT_TLOW_CYCLES 8'h20
`define IWT_THIGH_CYCLES 8'h20
`define IWT_GCALL 8'h00
`define IWT_ZERO8 8'h00
`endif

// [core/iwt_pkg.sv]
// Types shared by the word transfer block.
package iwt_pkg;
typedef enum logic [2:0] {
    IWT_IDLE = 3'b000,
    IWT_LOW = 3'b001,
    IWT_HIGH = 3'b010,
    IWT_HOLD = 3'b011,
    IWT_SLAVE = 3'b100
} iwt_state_t;
endpackage : iwt_pkg

// [core/iwt_sync.sv]
// Two-flop synchroniser for the bus pin levels.
`timescale 1ns/100ps
module iwt_sync (
    input wire logic clk,
    input wire logic nrst,
    input wire logic din,
    output logic dout
);
    logic meta_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : iwt_sync

// [tb/iwt_bus_model.sv]
// Behavioural model of another bus master, or of a slave transmitter, talking to the core.
`timescale 1ns/100ps
module iwt_bus_model (
    input wire logic clk,
    input wire logic scl_line,
    input wire logic sda_line,
    output logic scl_pull,
    output logic sda_pull
);
    logic timed_out = 1'b0;
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    task automatic half;
        repeat (3) @(posedge clk);
    endtask : half
    // A slave may stretch the clock, so wait for the line, not for our own release.
    task automatic rise;
        int n;
        n = 0;
        scl_pull <= 1'b0;
        @(posedge clk);
        while (scl_line !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (scl_line !== 1'b1) timed_out = 1'b1;
        half();
    endtask : rise
    // Data changes one cycle after the fall so it never moves while the clock is high.
    task automatic bit_cycle(input logic drive, output logic seen);
        @(posedge clk);
        sda_pull <= !drive;
        half();
        rise();
        seen = sda_line;
        scl_pull <= 1'b1;
    endtask : bit_cycle
    task automatic start_cond;
        sda_pull <= 1'b1;
        half();
        scl_pull <= 1'b1;
    endtask : start_cond
    task automatic stop_cond;
        @(posedge clk);
        sda_pull <= 1'b1;
        half();
        rise();
        sda_pull <= 1'b0;
        half();
    endtask : stop_cond
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
        bit_cycle(1'b1, ack);
    endtask : send_byte
    task automatic read_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            b[i] = s;
        end
        bit_cycle(nack, s);
    endtask : read_byte
    task automatic wait_line(input logic level);
        int n;
        n = 0;
        while (scl_line !== level && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (scl_line !== level) timed_out = 1'b1;
    endtask : wait_line
    // Slave transmitter for a master receive: data moves only after the clock has been seen low.
    task automatic serve(input logic [8:0] b, input int cnt, output logic [8:0] seen);
        seen = 9'h000;
        @(posedge clk);
        scl_pull <= 1'b0;
        for (int i = cnt - 1; i >= 0; i--) begin
            @(posedge clk);
            sda_pull <= !b[i];
            wait_line(1'b1);
            seen[i] = sda_line;
            wait_line(1'b0);
        end
    endtask : serve
endmodule : iwt_bus_model

// [tb/iwt_core_chk.sv]
// Port-level assertions for the word transfer core.
`timescale 1ns/100ps
`include "iwt_defs.svh"
module iwt_core_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic clock_pin_i,
    input wire logic clock_pin_o,
    input wire logic clock_pin_oe,
    input wire logic data_pin_i,
    input wire logic data_pin_o,
    input wire logic data_pin_oe,
    input wire logic serial_interrupt
);
    logic [7:0] hold_q;
    logic [7:0] quiet_q;
    logic resume_req;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    assign resume_req = avs_write && (avs_address == `IWT_OFS_DATA_BUF ||
        (avs_address == `IWT_OFS_CTRL_TWO && avs_writedata[`IWT_PIN_BIT]));
    // Both counters saturate so that a long stall cannot wrap into a false failure.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) hold_q <= 8'h00;
        else if (!clock_pin_oe) hold_q <= 8'h00;
        else if (hold_q != 8'hff) hold_q <= hold_q + 8'h01;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) quiet_q <= 8'hff;
        else if (serial_interrupt) quiet_q <= 8'h00;
        else if (quiet_q != 8'hff) quiet_q <= quiet_q + 8'h01;
    end
    sequence s_wait_one;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_irq_holds_clock: assert property (serial_interrupt && $past(serial_interrupt) |-> clock_pin_oe)
        else $error("clock not held while interrupt pending");
    a_hold_tlow: assert property ($fell(clock_pin_oe) |-> hold_q >= 8'h20)
        else $error("clock released before low period");
    a_irq_at_fall: assert property ($rose(serial_interrupt) |-> !clock_pin_i)
        else $error("interrupt raised while clock line high");
    a_irq_stays: assert property (serial_interrupt && !resume_req |=> serial_interrupt)
        else $error("interrupt dropped without resume");
    a_resume_clears: assert property (serial_interrupt && avs_write &&
        avs_address == `IWT_OFS_DATA_BUF |=> !serial_interrupt)
        else $error("data buffer write did not resume");
    a_no_early_irq: assert property ($rose(serial_interrupt) |-> quiet_q >= 8'h20)
        else $error("interrupt too soon after resume");
    a_status_pending: assert property (avs_read && !avs_waitrequest && avs_address == `IWT_OFS_STATUS_TWO
        |-> avs_readdata[4] == !$past(serial_interrupt) && avs_readdata[31:8] == 24'h00_0000)
        else $error("pending flag disagrees with interrupt");
    a_read_wait: assert property ($rose(avs_read) |-> s_wait_one)
        else $error("read answer not after one wait cycle");
    a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    a_open_drain: assert property (!clock_pin_o && !data_pin_o)
        else $error("pin driven high");
endmodule : iwt_core_chk
bind iwt_core iwt_core_chk u_iwt_core_chk (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .clock_pin_i(clock_pin_i),
    .clock_pin_o(clock_pin_o), .clock_pin_oe(clock_pin_oe), .data_pin_i(data_pin_i),
    .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe), .serial_interrupt(serial_interrupt));

// [tb/tb.sv]
// Bench: register access, slave addressing, data words and clock holds.
`timescale 1ns/100ps
`include "iwt_defs.svh"
module tb;
    logic clk, nrst, avs_read, avs_write, avs_waitrequest, ack;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic clock_pin_o, clock_pin_oe, data_pin_o, data_pin_oe, serial_interrupt, scl_pull, sda_pull;
    logic [7:0] rd;
    logic [8:0] seen;
    int err_total = 0;
    int comparisons = 0;
    // Both lines are open drain with pull-ups.
    wire scl_line = !(clock_pin_oe || scl_pull);
    wire sda_line = !(data_pin_oe || sda_pull);
    initial begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end
    iwt_core u_iwt_core (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .clock_pin_i(scl_line), .clock_pin_o(clock_pin_o),
        .clock_pin_oe(clock_pin_oe), .data_pin_i(sda_line), .data_pin_o(data_pin_o),
        .data_pin_oe(data_pin_oe), .serial_interrupt(serial_interrupt));
    iwt_bus_model u_iwt_bus_model (.clk(clk), .scl_line(scl_line), .sda_line(sda_line),
        .scl_pull(scl_pull), .sda_pull(sda_pull));
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    task automatic stuck;
        err_total++;
        wrap_up();
    endtask : stuck
    task automatic check(input logic [7:0] seen, input logic [7:0] expd, input string what);
        comparisons++;
        if (seen !== expd) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, expd, seen);
        end
    endtask : check
    task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (avs_waitrequest !== 1'b0) stuck();
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : access
    task automatic status(input logic [7:0] mask, input logic [7:0] expd);
        access(1'b0, `IWT_OFS_STATUS_TWO, 8'h00);
        check(rd & mask, expd, "status");
    endtask : status
    // With want low the full bound is spent, proving the interrupt stays quiet.
    task automatic wait_irq(input logic want);
        int n;
        n = 0;
        while (serial_interrupt !== 1'b1 && n < 1500) begin
            @(posedge clk);
            n++;
        end
        check(8'(serial_interrupt), 8'(want), "interrupt");
        if (want && serial_interrupt !== 1'b1) stuck();
    endtask : wait_irq
    task automatic resume(input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        access(1'b1, a, d);
        while (clock_pin_oe === 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        check(8'(n > 30 && n < 36), 8'h01, "clock hold after resume");
        check(8'(serial_interrupt), 8'h00, "interrupt after resume");
    endtask : resume
    task automatic address(input logic [7:0] b, input logic [7:0] mask, input logic [7:0] expd);
        u_iwt_bus_model.start_cond();
        u_iwt_bus_model.send_byte(b, ack);
        check(8'(ack), 8'h00, "address ack");
        wait_irq(1'b1);
        check(8'(clock_pin_oe), 8'h01, "clock held");
        status(mask, expd);
    endtask : address
    initial begin
        nrst = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0000_0000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        access(1'b0, `IWT_OFS_CTRL_ONE, 8'h00);
        check(rd, `IWT_CTRL_ONE_RST, "control one reset");
        status(8'h10, 8'h10);
        access(1'b1, 4'h7, 8'hff);
        access(1'b0, 4'h7, 8'h00);
        check(rd, 8'h00, "unmapped read");
        access(1'b1, `IWT_OFS_OWN_ADDR, 8'ha0);
        access(1'b0, `IWT_OFS_OWN_ADDR, 8'h00);
        check(rd, 8'ha0, "own address");
        access(1'b1, `IWT_OFS_CTRL_ONE, 8'h10);
        address(8'ha0, 8'h56, 8'h04);
        resume(`IWT_OFS_DATA_BUF, 8'h00);
        u_iwt_bus_model.send_byte(8'h5a, ack);
        check(8'(ack), 8'h00, "data ack");
        wait_irq(1'b1);
        status(8'h10, 8'h00);
        access(1'b0, `IWT_OFS_DATA_BUF, 8'h00);
        check(rd, 8'h5a, "received word");
        resume(`IWT_OFS_CTRL_TWO, 8'h10);
        u_iwt_bus_model.stop_cond();
        address(8'h00, 8'h06, 8'h06);
        resume(`IWT_OFS_DATA_BUF, 8'h00);
        u_iwt_bus_model.stop_cond();
        status(8'h02, 8'h00);
        access(1'b1, `IWT_OFS_CTRL_ONE, 8'h18);
        u_iwt_bus_model.start_cond();
        u_iwt_bus_model.send_byte(8'ha0, ack);
        check(8'(ack), 8'h01, "ack with detection off");
        wait_irq(1'b0);
        u_iwt_bus_model.stop_cond();
        access(1'b1, `IWT_OFS_CTRL_ONE, 8'h10);
        address(8'ha1, 8'h5e, 8'h44);
        access(1'b1, `IWT_OFS_DATA_BUF, 8'hc3);
        u_iwt_bus_model.read_byte(1'b0, rd);
        check(rd, 8'hc3, "sent word");
        wait_irq(1'b1);
        status(8'h4f, 8'h40);
        access(1'b1, `IWT_OFS_DATA_BUF, 8'h81);
        u_iwt_bus_model.read_byte(1'b1, rd);
        check(rd, 8'h81, "second sent word");
        wait_irq(1'b1);
        status(8'h4f, 8'h41);
        access(1'b1, `IWT_OFS_CTRL_TWO, 8'h50);
        access(1'b1, `IWT_OFS_CTRL_TWO, 8'h10);
        u_iwt_bus_model.stop_cond();
        access(1'b1, `IWT_OFS_CTRL_ONE, 8'h10);
        u_iwt_bus_model.start_cond();
        access(1'b1, `IWT_OFS_CTRL_TWO, 8'h90);
        u_iwt_bus_model.serve({8'h5a, 1'b1}, 9, seen);
        check(8'(seen[0]), 8'h00, "master ack");
        wait_irq(1'b1);
        status(8'hd0, 8'h80);
        access(1'b0, `IWT_OFS_DATA_BUF, 8'h00);
        access(1'b1, `IWT_OFS_CTRL_ONE, 8'h00);
        access(1'b1, `IWT_OFS_DATA_BUF, 8'h00);
        u_iwt_bus_model.serve({1'b0, 8'hc3}, 8, seen);
        wait_irq(1'b1);
        access(1'b0, `IWT_OFS_DATA_BUF, 8'h00);
        check(rd, 8'hc3, "last word");
        access(1'b1, `IWT_OFS_CTRL_ONE, 8'h01);
        access(1'b1, `IWT_OFS_DATA_BUF, 8'h00);
        u_iwt_bus_model.serve({8'h00, 1'b1}, 1, seen);
        check(8'(seen[0]), 8'h01, "released no-ack bit");
        wait_irq(1'b1);
        access(1'b1, `IWT_OFS_CTRL_TWO, 8'h10);
        u_iwt_bus_model.stop_cond();
        check(8'(u_iwt_bus_model.timed_out), 8'h00, "bus stall");
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge clk);
        stuck();
    end
endmodule : tb
